// File: hdl/wut_pkg.sv
// Package of the 32-bit wake-up timer: register map, field layout,
// reset values and the packed carriers used on the ports.
// Assumes a 32-bit APB master and source ticks synchronous to clk_i.
package wut_pkg;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [31:0] ADDR_RELOAD_VALUE = 32'hFFFF0340;
  localparam logic [31:0] ADDR_COUNT_VALUE = 32'hFFFF0344;
  localparam logic [31:0] ADDR_TIMER_CONTROL = 32'hFFFF0348;
  localparam logic [31:0] ADDR_INTERRUPT_CLEAR = 32'hFFFF034C;
  localparam logic [31:0] ADDR_INT_STATUS = 32'hFFFF0350;
  localparam logic [31:0] ADDR_INT_MASK = 32'hFFFF0354;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [31:0] RST_RELOAD_VALUE = 32'h00000000;
  localparam logic [31:0] RST_COUNT_VALUE = 32'hFFFFFFFF;
  localparam logic [10:0] RST_TIMER_CONTROL = 11'h000;
  localparam logic [0:0] RST_INT_STATUS = 1'h0;
  localparam logic [0:0] RST_INT_MASK = 1'h0;

  // ==========================================================================
  // Control field layout (bits 31..11 reserved, read as zero)
  // ==========================================================================
  localparam int CTRL_WIDTH = 11;
  localparam int CTRL_SCALE_LSB = 0;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CTRL_MODE_BIT = 6;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_DIR_BIT = 8;
  localparam int CTRL_CLKSEL_LSB = 9;
  localparam int INT_TIMEOUT_BIT = 0;

  // Clock source select codes
  localparam logic [1:0] CLKSEL_OSC32K = 2'h0;
  localparam logic [1:0] CLKSEL_CORE_DIV = 2'h1;
  localparam logic [1:0] CLKSEL_EXT_XTAL = 2'h2;
  localparam logic [1:0] CLKSEL_FULL = 2'h3;

  // Prescale codes and the prescale counter masks they select
  localparam logic [3:0] SCALE_DIV1 = 4'h0;
  localparam logic [3:0] SCALE_DIV16 = 4'h4;
  localparam logic [3:0] SCALE_DIV256 = 4'h8;
  localparam logic [3:0] SCALE_DIV32768 = 4'hF;
  localparam logic [14:0] MASK_DIV1 = 15'h0000;
  localparam logic [14:0] MASK_DIV16 = 15'h000F;
  localparam logic [14:0] MASK_DIV256 = 15'h00FF;
  localparam logic [14:0] MASK_DIV32768 = 15'h7FFF;

  // Count format codes
  localparam logic [1:0] FMT_BINARY = 2'h0;
  localparam logic [1:0] FMT_RESERVED = 2'h1;
  localparam logic [1:0] FMT_TOD23 = 2'h2;
  localparam logic [1:0] FMT_TOD255 = 2'h3;

  // Time-of-day field limits
  localparam logic [7:0] TOD_HUND_MAX = 8'h63;
  localparam logic [7:0] TOD_SEC_MAX = 8'h3B;
  localparam logic [7:0] TOD_MIN_MAX = 8'h3B;
  localparam logic [7:0] TOD_HR23_MAX = 8'h17;
  localparam logic [7:0] TOD_HR255_MAX = 8'hFF;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [1:0] clk_sel;
    logic dir;
    logic en;
    logic periodic;
    logic [1:0] fmt;
    logic [3:0] scale;
  } wut_ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } wut_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wut_apb_rsp_t;

  typedef struct packed {
    logic osc32k;
    logic core_div;
    logic ext_xtal;
  } wut_tick_t;

endpackage : wut_pkg

// File: hdl/wut_top.sv
// 32-bit wake-up timer with prescaler, binary or time-of-day count format,
// reload register, interrupt-clear register and APB register access.
// Assumes source ticks are one-cycle pulses synchronous to clk_i and an
// APB master that keeps to the protocol; the slave never inserts waits.
// Limitations worth knowing:
// - Core clock gating has no port; counting needs only clk_i and ticks
// - Time-of-day fields are plain binary per field, not BCD
// - Undefined prescale codes divide by one, reserved format counts binary
// - Overflow reloads only in periodic mode; free-running wraps
// - Writes to the count register are dropped without a bus error
`timescale 1ns/100ps

module wut_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // APB slave port
  input wut_pkg::wut_apb_req_t apb_req_i,
  output wut_pkg::wut_apb_rsp_t apb_rsp_o,
  // Source clock ticks, one cycle each
  input wut_pkg::wut_tick_t tick_i,
  // Interrupt
  output logic irq_o
);
  import wut_pkg::*;

  // ==========================================================================
  // Functions
  // ==========================================================================

  // Prescale code to counter mask; undefined codes fall back to divide by 1
  function automatic logic [14:0] scale_mask(input logic [3:0] code);
    logic [14:0] m;
    m = MASK_DIV1;
    case (code)
      SCALE_DIV16: m = MASK_DIV16;
      SCALE_DIV256: m = MASK_DIV256;
      SCALE_DIV32768: m = MASK_DIV32768;
      default: m = MASK_DIV1;
    endcase
    return m;
  endfunction : scale_mask

  // Address decode for the error answer; the read mux decodes on its own
  function automatic logic addr_mapped(input logic [31:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      ADDR_RELOAD_VALUE: hit = 1'b1;
      ADDR_COUNT_VALUE: hit = 1'b1;
      ADDR_TIMER_CONTROL: hit = 1'b1;
      ADDR_INTERRUPT_CLEAR: hit = 1'b1;
      ADDR_INT_STATUS: hit = 1'b1;
      ADDR_INT_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : addr_mapped

  // One step of a single time-of-day field; returns {carry, next}
  function automatic logic [8:0] field_step(input logic [7:0] v, input logic up,
                                            input logic [7:0] max);
    logic [8:0] r;
    r = {1'b0, v};
    if (up) begin
      if (v >= max) begin
        r = {1'b1, 8'h00};
      end else begin
        r = {1'b0, 8'(v + 8'h01)};
      end
    end else begin
      if (v == 8'h00 || v > max) begin
        r = {1'b1, max};
      end else begin
        r = {1'b0, 8'(v - 8'h01)};
      end
    end
    return r;
  endfunction : field_step

  // Hours:minutes:seconds:hundredths step; returns {terminal, next}
  function automatic logic [32:0] tod_step(input logic [31:0] v, input logic up,
                                           input logic [7:0] hr_max);
    logic [8:0] h;
    logic [8:0] s;
    logic [8:0] m;
    logic [8:0] hr;
    logic [31:0] n;
    h = field_step(v[7:0], up, TOD_HUND_MAX);
    s = field_step(v[15:8], up, TOD_SEC_MAX);
    m = field_step(v[23:16], up, TOD_MIN_MAX);
    hr = field_step(v[31:24], up, hr_max);
    // Carries ripple upward only through fields that wrapped
    n = v;
    n[7:0] = h[7:0];
    if (h[8]) begin
      n[15:8] = s[7:0];
      if (s[8]) begin
        n[23:16] = m[7:0];
        if (m[8]) begin
          n[31:24] = hr[7:0];
        end
      end
    end
    return {h[8] & s[8] & m[8] & hr[8], n};
  endfunction : tod_step

  // Plain binary step; returns {terminal, next}
  function automatic logic [32:0] bin_step(input logic [31:0] v, input logic up);
    logic [32:0] r;
    if (up) begin
      r = {(v == 32'hFFFFFFFF), 32'(v + 32'h00000001)};
    end else begin
      r = {(v == 32'h00000000), 32'(v - 32'h00000001)};
    end
    return r;
  endfunction : bin_step

  // ==========================================================================
  // Registers and internal signals
  // ==========================================================================
  // Register state
  wut_ctrl_t ctrl_q;
  logic [31:0] reload_value_q;
  logic [31:0] count_value_q;
  logic [31:0] count_value_d;
  logic [14:0] pre_cnt_q;
  logic [0:0] int_status_q;
  logic [0:0] int_mask_q;
  logic [31:0] prdata_q;

  // Decode and datapath nets
  logic apb_setup;
  logic apb_access;
  logic apb_rd_setup;
  logic apb_wr;
  logic wr_reload;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_status;
  logic wr_mask;
  logic src_tick;
  logic pre_tick;
  logic [14:0] pre_mask;
  logic step_en;
  logic [32:0] step_res;
  logic terminal;
  logic timeout;

  // ==========================================================================
  // APB decode
  // ==========================================================================

  // Zero-wait slave: access phase always completes in its first cycle
  assign apb_setup = apb_req_i.psel & ~apb_req_i.penable;
  assign apb_access = apb_req_i.psel & apb_req_i.penable;
  assign apb_wr = apb_access & apb_req_i.pwrite;
  assign apb_rd_setup = apb_setup & ~apb_req_i.pwrite;

  // Addresses must match a word exactly; anything else misses
  assign wr_reload = apb_wr & (apb_req_i.paddr == ADDR_RELOAD_VALUE);
  assign wr_ctrl = apb_wr & (apb_req_i.paddr == ADDR_TIMER_CONTROL);
  assign wr_clear = apb_wr & (apb_req_i.paddr == ADDR_INTERRUPT_CLEAR);
  assign wr_status = apb_wr & (apb_req_i.paddr == ADDR_INT_STATUS);
  assign wr_mask = apb_wr & (apb_req_i.paddr == ADDR_INT_MASK);

  // Response; read data comes from a flop loaded in the setup cycle
  // Error only in the access phase, so idle cycles stay quiet
  assign apb_rsp_o.prdata = prdata_q;
  assign apb_rsp_o.pready = 1'b1;
  assign apb_rsp_o.pslverr = apb_access & ~addr_mapped(apb_req_i.paddr);

  // ==========================================================================
  // Configuration registers
  // ==========================================================================

  // Control register; reserved bits are simply not stored
  // A write does not touch the count; a clear write restarts it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_q <= wut_ctrl_t'(RST_TIMER_CONTROL);
    end else if (wr_ctrl) begin
      ctrl_q <= wut_ctrl_t'(apb_req_i.pwdata[CTRL_WIDTH-1:0]);
    end
  end

  // Reload register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reload_value_q <= RST_RELOAD_VALUE;
    end else if (wr_reload) begin
      reload_value_q <= apb_req_i.pwdata;
    end
  end

  // Interrupt mask
  // One event source, so mask and status are a single bit
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      int_mask_q <= RST_INT_MASK;
    end else if (wr_mask) begin
      int_mask_q <= apb_req_i.pwdata[INT_TIMEOUT_BIT];
    end
  end

  // ==========================================================================
  // Clock source and prescaler
  // ==========================================================================

  // Source select; the full-rate choice ticks every cycle
  // Ticks are taken as already synchronous one-cycle pulses
  always_comb begin
    src_tick = 1'b0;
    case (ctrl_q.clk_sel)
      CLKSEL_OSC32K: src_tick = tick_i.osc32k;
      CLKSEL_CORE_DIV: src_tick = tick_i.core_div;
      CLKSEL_EXT_XTAL: src_tick = tick_i.ext_xtal;
      CLKSEL_FULL: src_tick = 1'b1;
      default: src_tick = 1'b0;
    endcase
  end

  // Mask of the low counter bits that make up one division
  assign pre_mask = scale_mask(ctrl_q.scale);

  // Prescale tick when the low counter bits are all ones for the division
  assign pre_tick = src_tick & ((pre_cnt_q & pre_mask) == pre_mask);

  // Prescale counter; held at zero while stopped so a restart is clean
  // A clear write restarts the division so the next period is whole
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pre_cnt_q <= 15'h0000;
    end else if (!ctrl_q.en || wr_clear) begin
      pre_cnt_q <= 15'h0000;
    end else if (src_tick) begin
      pre_cnt_q <= 15'(pre_cnt_q + 15'h0001);
    end
  end

  // ==========================================================================
  // Counter
  // ==========================================================================

  // Step in the chosen format; reserved format counts as binary
  always_comb begin
    step_res = bin_step(count_value_q, ctrl_q.dir);
    case (ctrl_q.fmt)
      FMT_TOD23: step_res = tod_step(count_value_q, ctrl_q.dir, TOD_HR23_MAX);
      FMT_TOD255: step_res = tod_step(count_value_q, ctrl_q.dir, TOD_HR255_MAX);
      FMT_BINARY: step_res = bin_step(count_value_q, ctrl_q.dir);
      FMT_RESERVED: step_res = bin_step(count_value_q, ctrl_q.dir);
      default: step_res = bin_step(count_value_q, ctrl_q.dir);
    endcase
  end

  // Nothing here depends on core clock gating, only on the source ticks
  assign step_en = ctrl_q.en & pre_tick;
  assign terminal = step_res[32];
  assign timeout = step_en & terminal;

  // Next count: clear-register reload wins over a step in the same cycle
  // Free-running terminal step falls through to the wrapped value
  always_comb begin
    count_value_d = count_value_q;
    if (wr_clear) begin
      count_value_d = reload_value_q;
    end else if (step_en) begin
      if (terminal && ctrl_q.periodic) begin
        count_value_d = reload_value_q;
      end else begin
        count_value_d = step_res[31:0];
      end
    end
  end

  // Count register
  // Reset value is all ones, so an enabled down count starts at full scale
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      count_value_q <= RST_COUNT_VALUE;
    end else begin
      count_value_q <= count_value_d;
    end
  end

  // ==========================================================================
  // Interrupt
  // ==========================================================================

  // Sticky status; a timeout in the clearing cycle is kept
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      int_status_q <= RST_INT_STATUS;
    end else if (timeout) begin
      int_status_q <= 1'b1;
    end else if (wr_clear) begin
      int_status_q <= 1'b0;
    end else if (wr_status && apb_req_i.pwdata[INT_TIMEOUT_BIT]) begin
      // Software write-one-to-clear, as an alternative to the clear register
      int_status_q <= 1'b0;
    end
  end

  // Level output while an unmasked status bit is set
  // Drops in the cycle after a clear or mask write lands
  assign irq_o = |(int_status_q & int_mask_q);

  // ==========================================================================
  // Read data
  // ==========================================================================

  // Sampled in the setup cycle, stable through the access phase
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prdata_q <= 32'h00000000;
    end else if (apb_rd_setup) begin
      case (apb_req_i.paddr)
        ADDR_RELOAD_VALUE: prdata_q <= reload_value_q;
        ADDR_COUNT_VALUE: prdata_q <= count_value_q;
        ADDR_TIMER_CONTROL: prdata_q <= {21'h000000, ctrl_q};
        ADDR_INT_STATUS: prdata_q <= {31'h00000000, int_status_q};
        ADDR_INT_MASK: prdata_q <= {31'h00000000, int_mask_q};
        // Clear register and unmapped addresses read as zero
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

endmodule : wut_top

// File: testbench/wut_top_monitor.sv
// Checker for the wake-up timer: concurrent assertions on top-level ports.
// Assumes a protocol-clean APB master and writes landing at access edges.
`timescale 1ns/100ps

module wut_top_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Observed ports
  input wut_pkg::wut_apb_req_t apb_req_i,
  input wut_pkg::wut_apb_rsp_t apb_rsp_o,
  input wut_pkg::wut_tick_t tick_i,
  input wire logic irq_o
);
  import wut_pkg::*;

  // ==========================================================================
  // Helper logic
  // ==========================================================================
  logic wr, rd, mapped, frozen_q;
  logic [31:0] a, reload_q, cnt_last_q;
  logic [10:0] ctrl_q;

  // Decoded access phase; map is six aligned words from the reload register
  assign a = apb_req_i.paddr;
  assign wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
  assign rd = apb_req_i.psel && apb_req_i.penable && !apb_req_i.pwrite;
  assign mapped = a >= ADDR_RELOAD_VALUE && a <= ADDR_INT_MASK && a[1:0] == 2'h0;

  // Shadow of the control and reload registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_q <= RST_TIMER_CONTROL;
      reload_q <= RST_RELOAD_VALUE;
    end else if (wr && a == ADDR_TIMER_CONTROL) begin
      ctrl_q <= apb_req_i.pwdata[10:0];
    end else if (wr && a == ADDR_RELOAD_VALUE) begin
      reload_q <= apb_req_i.pwdata;
    end
  end

  // Count known while stopped; a clear write preloads it from reload
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      frozen_q <= 1'b1;
      cnt_last_q <= RST_COUNT_VALUE;
    end else if (rd && a == ADDR_COUNT_VALUE) begin
      frozen_q <= !ctrl_q[CTRL_EN_BIT];
      cnt_last_q <= apb_rsp_o.prdata;
    end else if (wr && a == ADDR_INTERRUPT_CLEAR) begin
      frozen_q <= !ctrl_q[CTRL_EN_BIT];
      cnt_last_q <= reload_q;
    end else if (wr && a == ADDR_TIMER_CONTROL) begin
      frozen_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_reset_quiet;
    $rose(rstn_i) |-> !irq_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("irq high right after reset");

  property p_frozen;
    rd && a == ADDR_COUNT_VALUE && frozen_q |-> apb_rsp_o.prdata == cnt_last_q;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("count moved while stopped or clear did not reload");

  property p_ctrl_read;
    rd && a == ADDR_TIMER_CONTROL |-> apb_rsp_o.prdata == {21'h0, ctrl_q};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read differs from last write");

  property p_reload_read;
    rd && a == ADDR_RELOAD_VALUE |-> apb_rsp_o.prdata == reload_q;
  endproperty
  a_reload_read: assert property (p_reload_read)
    else $error("reload read differs from last write");

  property p_clr_drop;
    wr && a == ADDR_INTERRUPT_CLEAR && !ctrl_q[CTRL_EN_BIT] |=> !irq_o;
  endproperty
  a_clr_drop: assert property (p_clr_drop)
    else $error("irq survived a clear write");

  property p_irq_hold;
    irq_o && !wr |=> irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped without a write");

  property p_irq_cause;
    !ctrl_q[CTRL_EN_BIT] && !(wr && a == ADDR_INT_MASK) |=> !$rose(irq_o);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq rose while timer stopped");

  property p_bus_err;
    wr || rd |-> apb_rsp_o.pready && apb_rsp_o.pslverr == !mapped;
  endproperty
  a_bus_err: assert property (p_bus_err)
    else $error("bus error flag wrong");

  property p_rd_zero;
    rd && (!mapped || a == ADDR_INTERRUPT_CLEAR) |-> apb_rsp_o.prdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("write-only or unmapped read not zero");

endmodule : wut_top_monitor

bind wut_top wut_top_monitor u_mon (.clk_i(clk_i), .rstn_i(rstn_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .tick_i(tick_i), .irq_o(irq_o));

// File: testbench/wut_top_tb.sv
// Self-checking testbench for the wake-up timer over its APB port.
// Assumes the bound monitor and source ticks made here at fixed rates.
`timescale 1ns/100ps

module wut_top_tb;
  import wut_pkg::*;

  // ==========================================================================
  // Signals and tables
  // ==========================================================================
  logic clk_i, rstn_i, irq_o, e;
  wut_apb_req_t req;
  wut_apb_rsp_t rsp;
  wut_tick_t tick;
  logic [2:0] cyc;
  logic [31:0] v, c1, d;
  int error_cnt, num_checks, x;
  logic [31:0] ra[6] = '{ADDR_RELOAD_VALUE, ADDR_COUNT_VALUE, ADDR_TIMER_CONTROL,
    ADDR_INT_STATUS, ADDR_INT_MASK, ADDR_INTERRUPT_CLEAR};
  logic [31:0] rv[6] = '{32'h0, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [23:0] hi[4] = '{24'hFFFFFF, 24'hFFFFFF, 24'h173B3B, 24'hFF3B3B};
  // Select, prescale code, divisor, read spacing in cycles
  int tab[7][4] = '{'{3, 0, 1, 1024}, '{3, 4, 16, 1024}, '{3, 8, 256, 1024},
    '{3, 15, 32768, 65600}, '{0, 0, 4, 1024}, '{1, 0, 2, 1024}, '{2, 0, 8, 1024}};

  wut_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .tick_i(tick), .irq_o(irq_o));

  // Clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Source ticks at unlike rates so a wrong select shows up
  always @(posedge clk_i) begin
    cyc <= cyc + 3'h1;
    tick <= '{osc32k: cyc[1:0] == 2'h0, core_div: cyc[0], ext_xtal: cyc == 3'h0};
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] xp);
    num_checks++;
    if (s !== xp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, xp, s);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clk_i);
    req.penable <= 1'b1;
    // No cycle limit here; only the watchdog ends a wait
    do begin
      @(posedge clk_i);
    end while (rsp.pready !== 1'b1);
    v = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask : wr

  task automatic rd(input logic [31:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Irq sampled mid-cycle, after the write edge has landed
  task automatic chk_irq(input logic xp);
    @(negedge clk_i);
    chk("irq_o", {31'h0, irq_o}, {31'h0, xp});
  endtask : chk_irq

  function automatic logic [31:0] cw(int sel, int dir, int en, int per, int fmt, int sc);
    return 32'(sel * 512 + dir * 256 + en * 128 + per * 64 + fmt * 16 + sc);
  endfunction : cw

  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    rstn_i = 1'b0;
    req = '0;
    tick = '0;
    cyc = 3'h0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset value", v, rv[i]);
    end
    rd(32'hFFFF0358);
    chk("unmapped error", {31'h0, e}, 32'h1);
    wr(ADDR_COUNT_VALUE, 32'h1234);
    rd(ADDR_COUNT_VALUE);
    chk("count read only", v, 32'hFFFFFFFF);
    wr(ADDR_TIMER_CONTROL, 32'hFFFFFFFF);
    rd(ADDR_TIMER_CONTROL);
    chk("control bits", v, 32'h000007FF);
    wr(ADDR_TIMER_CONTROL, 32'h0);
    wr(ADDR_RELOAD_VALUE, 32'h5A5A0001);
    wr(ADDR_INTERRUPT_CLEAR, 32'hA5A5A5A5);
    rd(ADDR_COUNT_VALUE);
    chk("clear reloads", v, 32'h5A5A0001);
    rd(ADDR_INT_STATUS);
    chk("clear drops status", v, 32'h0);
    wr(ADDR_INT_MASK, 32'h1);
    // Wrap from zero downward in every format
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_TIMER_CONTROL, 32'h0);
      wr(ADDR_RELOAD_VALUE, 32'h0);
      wr(ADDR_INTERRUPT_CLEAR, 32'h0);
      chk_irq(1'b0);
      // Time-of-day formats run from the 32 kHz source divided by 256
      wr(ADDR_TIMER_CONTROL, f < 2 ? cw(3, 0, 1, 0, f, 0) : cw(0, 0, 1, 0, f, 8));
      if (f >= 2) begin
        repeat (1100) @(posedge clk_i);
      end
      rd(ADDR_COUNT_VALUE);
      chk("wrap value", {8'h0, v[31:8]}, {8'h0, hi[f]});
      chk_irq(1'b1);
    end
    wr(ADDR_TIMER_CONTROL, 32'h0);
    wr(ADDR_INT_MASK, 32'h0);
    chk_irq(1'b0);
    wr(ADDR_INT_MASK, 32'h1);
    chk_irq(1'b1);
    wr(ADDR_INT_STATUS, 32'h1);
    chk_irq(1'b0);
    // Periodic restart stays within reload and terminal
    for (int dd = 0; dd < 2; dd++) begin
      wr(ADDR_RELOAD_VALUE, dd ? 32'hFFFFFFFA : 32'h5);
      wr(ADDR_INTERRUPT_CLEAR, 32'h0);
      wr(ADDR_TIMER_CONTROL, cw(3, dd, 1, 1, 0, 0));
      repeat (4) begin
        rd(ADDR_COUNT_VALUE);
        chk("periodic range", {31'h0, dd ? v >= 32'hFFFFFFFA : v <= 32'h5},
          32'h1);
      end
      rd(ADDR_INT_STATUS);
      chk("timeout status", v, 32'h1);
      wr(ADDR_TIMER_CONTROL, 32'h0);
    end
    // Step rate for each source and prescale, direction alternating per entry
    foreach (tab[i]) begin
      wr(ADDR_TIMER_CONTROL, 32'h0);
      wr(ADDR_RELOAD_VALUE, 32'h00010000);
      wr(ADDR_INTERRUPT_CLEAR, 32'h0);
      wr(ADDR_TIMER_CONTROL, cw(tab[i][0], i % 2, 1, 0, 0, tab[i][1]));
      rd(ADDR_COUNT_VALUE);
      c1 = v;
      repeat (tab[i][3] - 3) @(posedge clk_i);
      rd(ADDR_COUNT_VALUE);
      d = (i % 2) ? v - c1 : c1 - v;
      x = tab[i][3] / tab[i][2];
      chk("step count", {31'h0, d + 1 >= x && d <= x + 1}, 32'h1);
    end
    report_and_stop();
  end

  // Watchdog, well past the longest expected run
  initial begin
    repeat (95000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end

endmodule : wut_top_tb
